// *** shared/fifo_ctrl_pkg.sv ***
// Package with register map, field positions, reset values and trigger tables.
`default_nettype none
package fifo_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_FIFO_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RX_FLUSH = 1;
  localparam int BIT_TX_FLUSH = 2;
  localparam int BIT_DMA_MODE = 3;
  localparam int POS_TX_TRIG = 4;
  localparam int POS_RX_TRIG = 6;
  localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_TX_TRIG = 1;
  localparam int IRQ_RX_TIMEOUT = 2;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] RX_TRIG_00 = 6'h08;
  localparam logic [5:0] RX_TRIG_01 = 6'h10;
  localparam logic [5:0] RX_TRIG_10 = 6'h18;
  localparam logic [5:0] RX_TRIG_11 = 6'h1C;
  localparam logic [5:0] TX_TRIG_00 = 6'h10;
  localparam logic [5:0] TX_TRIG_01 = 6'h08;
  localparam logic [5:0] TX_TRIG_10 = 6'h18;
  localparam logic [5:0] TX_TRIG_11 = 6'h1E;
endpackage
`default_nettype wire

// *** src/uart_fifo_control.sv ***
// FIFO control, trigger levels, DMA ready signalling and event interrupts of a UART.
//
// Chosen here: the address map and strobed register access.
`default_nettype none
// Operation
// - In mode 0 the transmit-ready output is low while nothing is held for transmit.
// - In mode 0 the receive-ready output is low while at least one character is held.
// - In mode 1 the transmit event is raised while transmit occupancy is below its trigger.
// - In mode 1 the receive event rises at the receive trigger and the queue still fills to full.
// - In mode 1 receive-ready stays low while the receive level is above the trigger.
// - Bits 7-6 select a receive trigger of 8, 16, 24 or 28 bytes.
// - Bits 5-4 select a transmit trigger of 16, 8, 24 or 30 bytes, 16 by default.
// - Bit 3 selects DMA mode 0 when clear and mode 1 when set while bit 0 is set, mode 0 after reset.
// - In FIFO mode 1 transmit-ready is high only when the transmit queue is full.
// - In FIFO mode 1 receive-ready falls at trigger or time-out and rises when empty.
// - Writing one to bit 2 flushes the transmit queue and the bit then reads zero.
// - Writing one to bit 1 flushes the receive queue and the bit then reads zero.
// - Bit 0 enables both queues, and disabled is the default.
// - Writes to the other control bits are ignored unless the same write sets bit 0.
// - The receive data interrupt stays set after occupancy drops below the trigger, until a one is written to clear it.
module uart_fifo_control
  import fifo_ctrl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [5:0] TX_LEVEL_IN,
  input wire logic TX_HOLD_FULL_IN,
  input wire logic [5:0] RX_LEVEL_IN,
  input wire logic RX_TIMEOUT_IN,
  output logic TX_FLUSH_OUT,
  output logic RX_FLUSH_OUT,
  output logic FIFO_ENABLE_OUT,
  output logic TX_DMA_REQUEST_N_OUT,
  output logic RX_DMA_REQUEST_N_OUT,
  output logic IRQ_OUT
);

  // ------------------------------------------------------------
  // Trigger lookup
  // ------------------------------------------------------------
  function automatic logic [5:0] rx_trig(input logic [1:0] code);
    unique case (code)
      2'h0: rx_trig = RX_TRIG_00;
      2'h1: rx_trig = RX_TRIG_01;
      2'h2: rx_trig = RX_TRIG_10;
      2'h3: rx_trig = RX_TRIG_11;
    endcase
  endfunction

  function automatic logic [5:0] tx_trig(input logic [1:0] code);
    unique case (code)
      2'h0: tx_trig = TX_TRIG_00;
      2'h1: tx_trig = TX_TRIG_01;
      2'h2: tx_trig = TX_TRIG_10;
      2'h3: tx_trig = TX_TRIG_11;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic enable_reg;
  logic dma_mode_reg;
  logic [1:0] tx_threshold_select_reg;
  logic [1:0] rx_threshold_select_reg;
  logic tx_flush_reg;
  logic rx_flush_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic rx_ready_n_reg;
  logic rx_event_prev_reg;
  logic tx_event_prev_reg;
  logic to_prev_reg;
  logic [7:0] rdata_next;

  wire wr_ctrl = WR_IN && (ADDR_IN == OFS_FIFO_CONTROL);
  wire wr_ctrl_ok = wr_ctrl && WDATA_IN[BIT_ENABLE];
  wire wr_istat = WR_IN && (ADDR_IN == OFS_IRQ_STATUS);
  wire wr_imask = WR_IN && (ADDR_IN == OFS_IRQ_MASK);
  wire [5:0] rx_trigger = rx_trig(rx_threshold_select_reg);
  wire [5:0] tx_trigger = tx_trig(tx_threshold_select_reg);
  wire mode1 = enable_reg && dma_mode_reg;
  wire tx_empty = (TX_LEVEL_IN == 6'h00) && !TX_HOLD_FULL_IN;
  wire tx_full = (TX_LEVEL_IN >= 6'(DEPTH));
  wire rx_any = (RX_LEVEL_IN != 6'h00);
  // Rx data condition is level based so it drops below trigger by itself.
  wire rx_trig_hit = enable_reg && (RX_LEVEL_IN >= rx_trigger);
  wire tx_below = enable_reg && (TX_LEVEL_IN < tx_trigger);
  wire [2:0] events = {RX_TIMEOUT_IN && !to_prev_reg,
                       tx_below && !tx_event_prev_reg,
                       rx_trig_hit && !rx_event_prev_reg};

  // ------------------------------------------------------------
  // FIFO control register
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      enable_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
      tx_threshold_select_reg <= 2'h0;
      rx_threshold_select_reg <= 2'h0;
      tx_flush_reg <= 1'b0;
      rx_flush_reg <= 1'b0;
    end else begin
      // Flush is a single-cycle action, so the bit self-clears next cycle.
      tx_flush_reg <= wr_ctrl_ok && WDATA_IN[BIT_TX_FLUSH];
      rx_flush_reg <= wr_ctrl_ok && WDATA_IN[BIT_RX_FLUSH];
      if (wr_ctrl) begin
        enable_reg <= WDATA_IN[BIT_ENABLE];
      end
      if (wr_ctrl_ok) begin
        dma_mode_reg <= WDATA_IN[BIT_DMA_MODE];
        tx_threshold_select_reg <= WDATA_IN[POS_TX_TRIG+:2];
        rx_threshold_select_reg <= WDATA_IN[POS_RX_TRIG+:2];
      end
    end
  end

  // ------------------------------------------------------------
  // DMA ready outputs
  // ------------------------------------------------------------
  // Mode 1 receive-ready is a latch: set at trigger or time-out, cleared only when empty.
  wire rx_ready_n_next = !rx_any ? 1'b1 :
                         (rx_trig_hit || RX_TIMEOUT_IN) ? 1'b0 : rx_ready_n_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      rx_ready_n_reg <= 1'b1;
      TX_DMA_REQUEST_N_OUT <= 1'b0;
      RX_DMA_REQUEST_N_OUT <= 1'b1;
    end else begin
      rx_ready_n_reg <= rx_ready_n_next;
      if (mode1) begin
        TX_DMA_REQUEST_N_OUT <= tx_full;
        RX_DMA_REQUEST_N_OUT <= rx_ready_n_next;
      end else begin
        TX_DMA_REQUEST_N_OUT <= !tx_empty;
        RX_DMA_REQUEST_N_OUT <= !rx_any;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= IRQ_MASK_RESET;
      rx_event_prev_reg <= 1'b0;
      tx_event_prev_reg <= 1'b0;
      to_prev_reg <= 1'b0;
    end else begin
      rx_event_prev_reg <= rx_trig_hit;
      tx_event_prev_reg <= tx_below;
      to_prev_reg <= RX_TIMEOUT_IN;
      // A new event wins over a write-one clear in the same cycle.
      irq_status_reg <= (irq_status_reg & ~(wr_istat ? WDATA_IN[2:0] : 3'h0)) | events;
      if (wr_imask) begin
        irq_mask_reg <= WDATA_IN[2:0];
      end
    end
  end

  assign IRQ_OUT = |(irq_status_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (ADDR_IN)
      OFS_FIFO_CONTROL: rdata_next = {rx_threshold_select_reg, tx_threshold_select_reg,
                                      dma_mode_reg, tx_flush_reg, rx_flush_reg, enable_reg};
      OFS_STATUS: rdata_next = {3'h0, tx_full, tx_below, rx_trig_hit,
                                RX_DMA_REQUEST_N_OUT, TX_DMA_REQUEST_N_OUT};
      OFS_IRQ_STATUS: rdata_next = {5'h00, irq_status_reg};
      OFS_IRQ_MASK: rdata_next = {5'h00, irq_mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= RD_IN ? rdata_next : 8'h00;
    end
  end

  assign TX_FLUSH_OUT = tx_flush_reg;
  assign RX_FLUSH_OUT = rx_flush_reg;
  assign FIFO_ENABLE_OUT = enable_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  // Back-to-back flush writes are legal, so a pulse is only judged when no second
  // flush write follows the first one.
  sequence s_flush_write;
    wr_ctrl && WDATA_IN[BIT_ENABLE] && WDATA_IN[BIT_TX_FLUSH];
  endsequence
  sequence s_no_flush_write;
    !(wr_ctrl_ok && WDATA_IN[BIT_TX_FLUSH]);
  endsequence
  sequence s_flush_pulse;
    TX_FLUSH_OUT ##1 !TX_FLUSH_OUT;
  endsequence
  sequence s_rx_flush_write;
    wr_ctrl_ok && WDATA_IN[BIT_RX_FLUSH];
  endsequence
  sequence s_no_rx_flush_write;
    !(wr_ctrl_ok && WDATA_IN[BIT_RX_FLUSH]);
  endsequence
  sequence s_rx_flush_pulse;
    RX_FLUSH_OUT ##1 !RX_FLUSH_OUT;
  endsequence

  a_mode0_tx_ready: assert property (!mode1 && tx_empty |=> !TX_DMA_REQUEST_N_OUT)
    else $error("tx ready not low in mode 0 while empty");
  a_mode0_rx_ready: assert property (!mode1 && rx_any |=> !RX_DMA_REQUEST_N_OUT)
    else $error("rx ready not low in mode 0 with data");
  a_tx_below_event: assert property ($rose(tx_below) |=> irq_status_reg[IRQ_TX_TRIG])
    else $error("tx trigger event not captured");
  a_rx_trig_event: assert property ($rose(rx_trig_hit) |=> irq_status_reg[IRQ_RX_TRIG])
    else $error("rx trigger event not captured");
  a_mode1_rx_hold: assert property (mode1 && rx_trig_hit |=> !RX_DMA_REQUEST_N_OUT)
    else $error("rx ready not low above trigger in mode 1");
  a_rx_trig_table: assert property (rx_threshold_select_reg == 2'h3 |-> rx_trigger == 6'h1C)
    else $error("rx trigger code 11 wrong");
  a_tx_trig_table: assert property (tx_threshold_select_reg == 2'h1 |-> tx_trigger == 6'h08)
    else $error("tx trigger code 01 wrong");
  a_mode1_tx_full: assert property (mode1 && !tx_full |=> !TX_DMA_REQUEST_N_OUT)
    else $error("tx ready high in mode 1 with free space");
  a_mode1_rx_empty: assert property (mode1 && !rx_any |=> RX_DMA_REQUEST_N_OUT)
    else $error("rx ready low in mode 1 while empty");
  a_tx_flush_pulse: assert property (s_flush_write ##1 s_no_flush_write |-> s_flush_pulse)
    else $error("tx flush not a one-cycle pulse");
  a_rx_flush_pulse: assert property (s_rx_flush_write ##1 s_no_rx_flush_write |-> s_rx_flush_pulse)
    else $error("rx flush did not self-clear");
  a_ignored_write: assert property (wr_ctrl && !WDATA_IN[BIT_ENABLE] |=>
      $stable(dma_mode_reg) && !tx_flush_reg && !rx_flush_reg)
    else $error("control bits changed without enable");
  a_rx_irq_drop: assert property (enable_reg && (RX_LEVEL_IN < rx_trigger) |-> !rx_trig_hit)
    else $error("rx data condition behaved wrongly on drop");

  // ------------------------------------------------------------
  // Checks on the ready outputs
  // ------------------------------------------------------------
  // Both polarities are checked, so a stuck output cannot pass either way.
  a_mode0_tx_busy: assert property (!mode1 && !tx_empty |=> TX_DMA_REQUEST_N_OUT)
    else $error("tx ready low in mode 0 while a word is held");
  a_mode0_rx_idle: assert property (!mode1 && !rx_any |=> RX_DMA_REQUEST_N_OUT)
    else $error("rx ready low in mode 0 while empty");
  a_mode1_rx_latched: assert property (mode1 && rx_any && !rx_ready_n_reg |=> !RX_DMA_REQUEST_N_OUT)
    else $error("rx ready released in mode 1 with data held");
  a_mode1_tx_request: assert property (mode1 && tx_full |=> TX_DMA_REQUEST_N_OUT)
    else $error("tx ready low in mode 1 while full");
  a_mode1_rx_timeout: assert property (mode1 && rx_any && RX_TIMEOUT_IN |=> !RX_DMA_REQUEST_N_OUT)
    else $error("rx ready not low in mode 1 after time-out");

  // ------------------------------------------------------------
  // Checks on triggers and events
  // ------------------------------------------------------------
  a_tx_below_level: assert property (enable_reg && (TX_LEVEL_IN < tx_trigger) |-> tx_below)
    else $error("tx below condition missing");
  a_rx_past_trigger: assert property (enable_reg && (RX_LEVEL_IN > rx_trigger) |-> rx_trig_hit)
    else $error("rx trigger condition lost above the trigger");
  a_rx_trig_default: assert property (rx_threshold_select_reg == 2'h0 |-> rx_trigger == 6'h08)
    else $error("rx trigger code 00 wrong");
  a_tx_trig_default: assert property (tx_threshold_select_reg == 2'h0 |-> tx_trigger == 6'h10)
    else $error("tx trigger code 00 wrong");
  a_timeout_event: assert property ($rose(RX_TIMEOUT_IN) |=> irq_status_reg[IRQ_RX_TIMEOUT])
    else $error("time-out event not captured");
  a_rx_drop_level: assert property ($fell(rx_trig_hit) && enable_reg |-> RX_LEVEL_IN < rx_trigger)
    else $error("rx data condition dropped at or above the trigger");

  // ------------------------------------------------------------
  // Checks on control writes
  // ------------------------------------------------------------
  // Reset is the one place where the default disable must not apply.
  a_reset_clears: assert property (disable iff (1'b0) RST_IN |=> !enable_reg && !dma_mode_reg &&
      tx_threshold_select_reg == 2'h0 && rx_threshold_select_reg == 2'h0 && !tx_flush_reg)
    else $error("control fields not cleared by reset");
  a_dma_mode_write: assert property (wr_ctrl_ok |=> dma_mode_reg == $past(WDATA_IN[BIT_DMA_MODE]))
    else $error("dma mode bit not taken");
  a_tx_flush_set: assert property (s_flush_write |=> TX_FLUSH_OUT)
    else $error("tx flush not raised");
  a_rx_flush_set: assert property (s_rx_flush_write |=> RX_FLUSH_OUT)
    else $error("rx flush not raised");
  a_enable_write: assert property (wr_ctrl |=> enable_reg == $past(WDATA_IN[BIT_ENABLE]))
    else $error("enable bit not taken");
  a_ignored_trigger: assert property (wr_ctrl && !WDATA_IN[BIT_ENABLE] |=>
      $stable(rx_threshold_select_reg) && $stable(tx_threshold_select_reg))
    else $error("trigger fields changed without enable");

endmodule
`default_nettype wire

// *** verif/uart_queue_side.sv ***
// Far-side queue model that holds the transmit and receive occupancy.
`default_nettype none
module uart_queue_side (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [5:0] tx_set_in,
  input wire logic [5:0] rx_set_in,
  input wire logic tx_flush_in,
  input wire logic rx_flush_in,
  output logic [5:0] tx_level_out,
  output logic [5:0] rx_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A flush beats a load in the same cycle, as it resets the counters outright.
  always_ff @(posedge clk_in) begin
    if (rst_in || tx_flush_in) begin
      tx_level_out <= 6'h00;
    end else if (load_in) begin
      tx_level_out <= tx_set_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || rx_flush_in) begin
      rx_level_out <= 6'h00;
    end else if (load_in) begin
      rx_level_out <= rx_set_in;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_uart_fifo_control_dma_ready.sv ***
// Self-checking bench for the FIFO control block against a reference model.
`default_nettype none
module tb_uart_fifo_control_dma_ready;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, hold = 1'b0, to = 1'b0, ld = 1'b0;
  logic [fifo_ctrl_pkg::ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00, rdata, ctrl;
  logic [5:0] tx_set = 6'h00, rx_set = 6'h00, tx_lv, rx_lv;
  logic txf, rxf, fen, txn, rxn, irq, exp_tx, exp_rx, rxl;
  logic [15:0] seed = 16'h7C7B;
  int bad_count = 0, comparisons = 0, quiet = 0;
  int rt[4] = '{8, 16, 24, 28};
  int tt[4] = '{16, 8, 24, 30};
  always #5 clk = ~clk;
  uart_fifo_control dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TX_LEVEL_IN(tx_lv), .TX_HOLD_FULL_IN(hold),
    .RX_LEVEL_IN(rx_lv), .RX_TIMEOUT_IN(to), .TX_FLUSH_OUT(txf), .RX_FLUSH_OUT(rxf),
    .FIFO_ENABLE_OUT(fen), .TX_DMA_REQUEST_N_OUT(txn), .RX_DMA_REQUEST_N_OUT(rxn), .IRQ_OUT(irq));
  uart_queue_side far_u (.clk_in(clk), .rst_in(rst), .load_in(ld), .tx_set_in(tx_set),
    .rx_set_in(rx_set), .tx_flush_in(txf), .rx_flush_in(rxf), .tx_level_out(tx_lv),
    .rx_level_out(rx_lv));
  // ----
  // Reference model. Ready outputs are only judged three cycles after a control write,
  // so the exact cycle in which a new mode takes hold is left to the design.
  // ----
  always @(posedge clk) begin
    if (rst) begin
      ctrl = 8'h00;
      rxl = 1'b0;
      quiet = 0;
    end else begin
      exp_tx = (ctrl[0] && ctrl[3]) ? (tx_lv == 6'h20) : (tx_lv != 6'h00 || hold);
      rxl = (rx_lv >= rt[ctrl[7:6]] || to) ? 1'b1 : (rx_lv == 6'h00) ? 1'b0 : rxl;
      exp_rx = (ctrl[0] && ctrl[3]) ? !rxl : (rx_lv == 6'h00);
      quiet = quiet + 1;
      if (wr && addr == 4'h0) begin
        quiet = 0;
        ctrl = wdata[0] ? (wdata & 8'hF9) : (ctrl & 8'hFE);
      end
    end
  end
  always @(negedge clk) begin
    if (!rst && quiet >= 3) begin
      cmp_pin("tx_request_n", exp_tx, txn);
      cmp_pin("rx_request_n", exp_rx, rxn);
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_pin(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cmp_reg(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    cmp_pin("tx_flush", a == 4'h0 && d[0] && d[2], txf);
    cmp_pin("rx_flush", a == 4'h0 && d[0] && d[1], rxf);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp_reg("read_data", e, rdata);
    cmp_pin("fifo_enable", ctrl[0], fen);
    cmp_pin("flush_idle", 1'b0, txf | rxf);
  endtask
  // Time-out is raised in the cycle after the load, so it never meets an empty queue.
  task automatic lv(input int t, input int r, input logic h, input logic o);
    @(posedge clk);
    tx_set <= 6'(t);
    rx_set <= 6'(r);
    hold <= h;
    to <= 1'b0;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    to <= o;
  endtask
  task automatic churn(input int n);
    int t;
    int r;
    repeat (n) begin
      seed = lfsr(seed);
      t = !ctrl[0] ? 0 : (seed[6:5] == 2'h0) ? 32 : seed[4:0];
      r = ctrl[0] ? seed[13:8] % 33 : seed[8];
      lv(t, r, seed[14], seed[15:13] == 3'h0 && r != 0);
    end
  endtask
  task automatic irq_seq(input int rtg, input int ttg);
    lv(32, 0, 1'b0, 1'b0);
    wr_reg(4'h3, 8'h07);
    rd_reg(4'h3, 8'h07);
    wr_reg(4'h2, 8'h07);
    rd_reg(4'h2, 8'h00);
    lv(ttg, rtg - 1, 1'b0, 1'b0);
    lv(ttg - 1, rtg - 1, 1'b0, 1'b0);
    rd_reg(4'h2, 8'h02);
    lv(ttg - 1, rtg, 1'b0, 1'b0);
    rd_reg(4'h2, 8'h03);
    cmp_pin("irq", 1'b1, irq);
    lv(32, 32, 1'b0, 1'b1);
    rd_reg(4'h1, 8'h15);
    wr_reg(4'h3, 8'h00);
    cmp_pin("irq_masked", 1'b0, irq);
    wr_reg(4'h2, 8'h03);
    rd_reg(4'h2, 8'h04);
    lv(ttg - 1, rtg - 1, 1'b0, 1'b0);
    rd_reg(4'h1, 8'h08);
    wr_reg(4'h2, 8'h07);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h00);
    cmp_pin("irq_idle", 1'b0, irq);
    wr_reg(4'h0, 8'hF8);
    rd_reg(4'h0, 8'h00);
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 4; s++) begin
        lv(0, 0, 1'b0, 1'b0);
        wr_reg(4'h0, {2'(s), 2'(3 - s), 1'(d), 3'h7});
        rd_reg(4'h0, {2'(s), 2'(3 - s), 1'(d), 3'h1});
        churn(40);
        if (d == 1) irq_seq(rt[s], tt[3 - s]);
      end
    end
    lv(0, 0, 1'b0, 1'b0);
    wr_reg(4'h0, 8'hFE);
    rd_reg(4'h0, 8'hC8);
    churn(40);
    rd_reg(4'hF, 8'h00);
    wrap_up();
  end
  // The full run needs under a thousand cycles, so this limit only trips on a hang.
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
